// >>> spp_consts.svh
`ifndef SPP_CONSTS_SVH
`define SPP_CONSTS_SVH

// register indices; the byte address on the bus is four times the index
`define SPP_IDX_CONTROL 6'h0a
`define SPP_IDX_STATUS 6'h0b
`define SPP_IDX_DATA 6'h0c
`define SPP_IDX_EVT_STATUS 6'h0d
`define SPP_IDX_EVT_CLEAR 6'h0e
`define SPP_IDX_EVT_ENABLE 6'h0f

// status register bit positions
`define SPP_ST_DONE 7
`define SPP_ST_WRITE_COLLISION_FLAG 6
`define SPP_ST_MODE_FAULT_FLAG 4

// event register bit positions
`define SPP_EV_DONE 0
`define SPP_EV_WRITE_COLLISION_FLAG 1
`define SPP_EV_MODE_FAULT_FLAG 2
`define SPP_EV_OVRN 3
`define SPP_EV_W 4

// reset values
`define SPP_CTL_RESET 8'h00
`define SPP_EV_RESET 4'h0

// half serial clock periods in processor clocks for rate codes 00..11
`define SPP_HALF_DIV2 5'h01
`define SPP_HALF_DIV4 5'h02
`define SPP_HALF_DIV16 5'h08
`define SPP_HALF_DIV32 5'h10

// clock edges in one byte frame, last edge index
`define SPP_LAST_EDGE 4'hf

// axi responses
`define SPP_RESP_OKAY 2'h0
`define SPP_RESP_SLVERR 2'h2

`endif

// >>> spp_pkg.sv
package spp_pkg;

  // master engine states
  typedef enum logic {
    SPP_IDLE,
    SPP_SHIFT
  } spp_state_e;

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic portInterruptEnable;
    logic portSystemEnable;
    logic wireOrMode;
    logic masterSelect;
    logic clockPolarity;
    logic clockPhase;
    logic rateSelectHigh;
    logic rateSelectLow;
  } spp_ctrl_s;

endpackage : spp_pkg

// >>> spp_rate_if.sv
`timescale 1ns/10ps
`default_nettype none

// rate select and run request to the divider, half period tick back
interface spp_rate_if;
  logic [1:0] rate;
  logic run;
  logic tick;
  modport gen (input rate, input run, output tick);
  modport user (output rate, output run, input tick);
endinterface : spp_rate_if

`default_nettype wire

// >>> spp_rate_gen.sv
`timescale 1ns/10ps
`default_nettype none
`include "spp_consts.svh"

module spp_rate_gen (
  input wire logic clk,
  input wire logic rst,
  spp_rate_if.gen rif
);

  logic [4:0] halfCnt;

  // half period length in processor clocks for a rate code
  function automatic logic [4:0] halfLen(input logic [1:0] code);
    case (code)
      2'h0: halfLen = `SPP_HALF_DIV2;
      2'h1: halfLen = `SPP_HALF_DIV4;
      2'h2: halfLen = `SPP_HALF_DIV16;
      default: halfLen = `SPP_HALF_DIV32;
    endcase
  endfunction : halfLen

  // one-cycle tick at every half serial clock period while running
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      halfCnt <= 5'h00;
      rif.tick <= 1'b0;
    end else if (!rif.run) begin
      halfCnt <= 5'h00;
      rif.tick <= 1'b0;
    end else if (halfCnt == halfLen(rif.rate) - 5'h01) begin
      halfCnt <= 5'h00;
      rif.tick <= 1'b1;
    end else begin
      halfCnt <= halfCnt + 5'h01;
      rif.tick <= 1'b0;
    end
  end

endmodule : spp_rate_gen

`default_nettype wire

// >>> spp_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "spp_consts.svh"

// Behaviour
// - interrupt while done flag and enable set
// - system enable turns port on/off
// - master select: 1 master, 0 slave
// - phase with polarity picks sampling edge
// - master rate: divide by 2,4,16,32
// - rate ignored in slave mode
// - data write loads shift register directly
// - only master data write starts transfer
// - done flag set when byte completes
// - data read returns receive buffer
// - overrun when done still set; byte dropped
// - done clears: status read, data access
// - collision on data write while busy
// - mode fault clears: status read, control write
// - control bit 5 selects open drain
// - reset clears enables and flags
// - unused status bits read zero
module spp_top
  import spp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOe,
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOe,
  input wire logic selectN,
  output logic irq
);

  spp_rate_if rif ();

  spp_ctrl_s ctrl;
  spp_state_e state;
  logic transferDoneFlag;
  logic writeCollisionFlag;
  logic modeFaultFlag;
  logic doneArm;
  logic collisionArm;
  logic faultArm;
  logic [3:0] evtStatus;
  logic [3:0] evtEnable;
  logic [7:0] rxBuffer;
  logic [7:0] shiftReg;
  logic outBit;
  logic [3:0] edgeCnt;
  logic sckLevel;
  logic prevSck;
  logic awHeld;
  logic wHeld;
  logic [ADDR_W-1:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  logic next_awHeld;
  logic next_wHeld;
  logic next_rvalid;
  logic doWrite;
  logic arFire;
  logic ctrlWrite;
  logic dataWrite;
  logic statusRead;
  logic dataRead;
  logic dataAccess;
  logic slaveSel;
  logic masterOn;
  logic busy;
  logic fault;
  logic edgeEvt;
  logic sampleEdge;
  logic inBit;
  logic done;
  logic overrun;
  logic [7:0] rxByte;
  logic [31:0] readValue;
  logic readHit;
  logic next_sckLevel;
  logic next_outBit;

  // true when a word address selects the register index
  function automatic logic regHit(input logic [ADDR_W-1:0] addr, input logic [5:0] idx);
    regHit = (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction : regHit

  // divider runs only while the master engine shifts
  assign rif.rate = {ctrl.rateSelectHigh, ctrl.rateSelectLow};
  assign rif.run = (state == SPP_SHIFT);

  spp_rate_gen u_rate (
    .clk(clk),
    .rst(rst),
    .rif(rif)
  );

  // bus handshake terms
  assign doWrite = awHeld && wHeld && !bvalid;
  assign arFire = arvalid && arready;
  assign next_awHeld = (awvalid && awready) ? 1'b1 : (doWrite ? 1'b0 : awHeld);
  assign next_wHeld = (wvalid && wready) ? 1'b1 : (doWrite ? 1'b0 : wHeld);
  assign next_rvalid = arFire ? 1'b1 : ((rvalid && rready) ? 1'b0 : rvalid);

  // register access strobes with their side effects
  assign ctrlWrite = doWrite && regHit(awAddrQ, `SPP_IDX_CONTROL) && wStrbQ[0];
  assign dataWrite = doWrite && regHit(awAddrQ, `SPP_IDX_DATA) && wStrbQ[0];
  assign statusRead = arFire && regHit(araddr, `SPP_IDX_STATUS);
  assign dataRead = arFire && regHit(araddr, `SPP_IDX_DATA);
  assign dataAccess = dataRead || (doWrite && regHit(awAddrQ, `SPP_IDX_DATA));

  // port modes and transfer progress
  assign masterOn = ctrl.portSystemEnable && ctrl.masterSelect;
  assign slaveSel = ctrl.portSystemEnable && !ctrl.masterSelect && !selectN;
  assign fault = masterOn && !selectN;
  assign busy = (state == SPP_SHIFT) || (slaveSel && edgeCnt != 4'h0);
  assign edgeEvt = ((state == SPP_SHIFT) && rif.tick) || (slaveSel && sckIn != prevSck);
  assign sampleEdge = edgeCnt[0] ^ ~ctrl.clockPhase;
  assign inBit = ctrl.masterSelect ? misoIn : mosiIn;
  assign done = edgeEvt && edgeCnt == `SPP_LAST_EDGE;
  assign overrun = done && transferDoneFlag;
  assign rxByte = sampleEdge ? {shiftReg[6:0], inBit} : shiftReg;

  // next output bit: loaded by a data write, moved on each drive edge
  assign next_outBit = (dataWrite && !busy) ? wDataQ[7] :
      ((edgeEvt && !sampleEdge && !fault && (slaveSel || state == SPP_SHIFT)) ?
      shiftReg[7] : outBit);
  // next clock level; pins follow it at once, so at divide by 2 the
  // far side's bit has settled when the sampling pin edge appears
  assign next_sckLevel = (state == SPP_SHIFT && rif.tick && !done) ? ~sckLevel :
      ((state != SPP_SHIFT || done) ? ctrl.clockPolarity : sckLevel);

  // write address and data channels, taken in either order
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      awAddrQ <= '0;
      wDataQ <= 32'h00000000;
      wStrbQ <= 4'h0;
    end else begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awready <= !next_awHeld;
      wready <= !next_wHeld;
      if (awvalid && awready) begin
        awAddrQ <= awaddr;
      end
      if (wvalid && wready) begin
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end
    end
  end

  // write response, unmapped addresses answer with an error
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp <= `SPP_RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      if (regHit(awAddrQ, `SPP_IDX_CONTROL) || regHit(awAddrQ, `SPP_IDX_DATA) ||
          regHit(awAddrQ, `SPP_IDX_EVT_CLEAR) || regHit(awAddrQ, `SPP_IDX_EVT_ENABLE) ||
          regHit(awAddrQ, `SPP_IDX_STATUS) || regHit(awAddrQ, `SPP_IDX_EVT_STATUS)) begin
        bresp <= `SPP_RESP_OKAY;
      end else begin
        bresp <= `SPP_RESP_SLVERR;
      end
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read data selection
  always_comb begin
    readValue = 32'h00000000;
    readHit = 1'b1;
    if (regHit(araddr, `SPP_IDX_CONTROL)) begin
      readValue[7:0] = ctrl;
    end else if (regHit(araddr, `SPP_IDX_STATUS)) begin
      readValue[`SPP_ST_DONE] = transferDoneFlag;
      readValue[`SPP_ST_WRITE_COLLISION_FLAG] = writeCollisionFlag;
      readValue[`SPP_ST_MODE_FAULT_FLAG] = modeFaultFlag;
    end else if (regHit(araddr, `SPP_IDX_DATA)) begin
      readValue[7:0] = rxBuffer;
    end else if (regHit(araddr, `SPP_IDX_EVT_STATUS)) begin
      readValue[3:0] = evtStatus;
    end else if (regHit(araddr, `SPP_IDX_EVT_ENABLE)) begin
      readValue[3:0] = evtEnable;
    end else if (!regHit(araddr, `SPP_IDX_EVT_CLEAR)) begin
      readHit = 1'b0;
    end
  end

  // read channel, one outstanding read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      arready <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `SPP_RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      arready <= !next_rvalid;
      if (arFire) begin
        rdata <= readValue;
        rresp <= readHit ? `SPP_RESP_OKAY : `SPP_RESP_SLVERR;
      end
    end
  end

  // control register; a mode fault drops master mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= `SPP_CTL_RESET;
    end else begin
      if (ctrlWrite) begin
        ctrl <= spp_ctrl_s'(wDataQ[7:0]);
      end
      if (fault) begin
        ctrl.masterSelect <= 1'b0;
      end
    end
  end

  // arming by a status read; the following access clears
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      doneArm <= 1'b0;
      collisionArm <= 1'b0;
      faultArm <= 1'b0;
    end else begin
      if (statusRead && transferDoneFlag) begin
        doneArm <= 1'b1;
      end else if (dataAccess) begin
        doneArm <= 1'b0;
      end
      if (statusRead && writeCollisionFlag) begin
        collisionArm <= 1'b1;
      end else if (dataAccess) begin
        collisionArm <= 1'b0;
      end
      if (statusRead && modeFaultFlag) begin
        faultArm <= 1'b1;
      end else if (ctrlWrite) begin
        faultArm <= 1'b0;
      end
    end
  end

  // status flags, a set in the clearing cycle wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      transferDoneFlag <= 1'b0;
      writeCollisionFlag <= 1'b0;
      modeFaultFlag <= 1'b0;
    end else begin
      if (done) begin
        transferDoneFlag <= 1'b1;
      end else if (doneArm && dataAccess) begin
        transferDoneFlag <= 1'b0;
      end
      if (dataWrite && busy) begin
        writeCollisionFlag <= 1'b1;
      end else if (collisionArm && dataAccess) begin
        writeCollisionFlag <= 1'b0;
      end
      if (fault) begin
        modeFaultFlag <= 1'b1;
      end else if (faultArm && ctrlWrite) begin
        modeFaultFlag <= 1'b0;
      end
    end
  end

  // receive buffer keeps the older byte on overrun
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxBuffer <= 8'h00;
    end else if (done && !overrun) begin
      rxBuffer <= rxByte;
    end
  end

  // master engine: only a data write in master mode starts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= SPP_IDLE;
    end else begin
      case (state)
        SPP_IDLE: begin
          if (dataWrite && !busy && masterOn && !fault) begin
            state <= SPP_SHIFT;
          end
        end
        SPP_SHIFT: begin
          if (done || fault || !masterOn) begin
            state <= SPP_IDLE;
          end
        end
        default: begin
          state <= SPP_IDLE;
        end
      endcase
    end
  end

  // shift register and edge count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shiftReg <= 8'h00;
      edgeCnt <= 4'h0;
    end else if (dataWrite && !busy) begin
      shiftReg <= wDataQ[7:0];
      edgeCnt <= 4'h0;
    end else if (fault || (!slaveSel && state != SPP_SHIFT)) begin
      edgeCnt <= 4'h0;
    end else if (edgeEvt) begin
      edgeCnt <= edgeCnt + 4'h1;
      if (sampleEdge) begin
        shiftReg <= {shiftReg[6:0], inBit};
      end
    end
  end

  // output bit register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outBit <= 1'b0;
    end else begin
      outBit <= next_outBit;
    end
  end

  // master serial clock level, toggled on each half period tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sckLevel <= 1'b0;
    end else begin
      sckLevel <= next_sckLevel;
    end
  end

  // previous serial clock input, for slave edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prevSck <= 1'b0;
    end else if (slaveSel) begin
      prevSck <= sckIn;
    end else begin
      prevSck <= ctrl.clockPolarity;
    end
  end

  // pin drivers; open drain drives only a low level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sckOut <= 1'b0;
      sckOe <= 1'b0;
      mosiOut <= 1'b0;
      mosiOe <= 1'b0;
      misoOut <= 1'b0;
      misoOe <= 1'b0;
    end else begin
      sckOut <= next_sckLevel;
      mosiOut <= next_outBit;
      misoOut <= next_outBit;
      sckOe <= masterOn && !fault && (!ctrl.wireOrMode || !next_sckLevel);
      mosiOe <= masterOn && !fault && (!ctrl.wireOrMode || !next_outBit);
      misoOe <= slaveSel && (!ctrl.wireOrMode || !next_outBit);
    end
  end

  // sticky events, enables and write-one clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evtStatus <= `SPP_EV_RESET;
      evtEnable <= `SPP_EV_RESET;
    end else begin
      if (doWrite && regHit(awAddrQ, `SPP_IDX_EVT_ENABLE) && wStrbQ[0]) begin
        evtEnable <= wDataQ[3:0];
      end
      for (int i = 0; i < `SPP_EV_W; i++) begin
        if (doWrite && regHit(awAddrQ, `SPP_IDX_EVT_CLEAR) && wStrbQ[0] && wDataQ[i]) begin
          evtStatus[i] <= 1'b0;
        end
      end
      if (done) begin
        evtStatus[`SPP_EV_DONE] <= 1'b1;
      end
      if (dataWrite && busy) begin
        evtStatus[`SPP_EV_WRITE_COLLISION_FLAG] <= 1'b1;
      end
      if (fault) begin
        evtStatus[`SPP_EV_MODE_FAULT_FLAG] <= 1'b1;
      end
      if (overrun) begin
        evtStatus[`SPP_EV_OVRN] <= 1'b1;
      end
    end
  end

  // interrupt line
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (ctrl.portInterruptEnable && transferDoneFlag) || (|(evtStatus & evtEnable));
    end
  end

endmodule : spp_top

`default_nettype wire

// >>> spp_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// bus handshake and pin release checks at the top ports
module spp_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic sckOe,
  input wire logic mosiOe,
  input wire logic misoOe,
  input wire logic selectN,
  input wire logic irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // answers stand until taken
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write answer late");
  a_ar_blocked: assert property (rvalid |-> !arready)
    else $error("second read taken");
  a_refused_zero: assert property (rvalid && rresp == 2'h2 |-> rdata == 32'h0)
    else $error("refused read not zero");
  a_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  // a foreign select in master mode takes the port off the pins
  a_fault_release: assert property (sckOe && !selectN |-> ##[1:3] !sckOe && !mosiOe)
    else $error("pins kept on fault");
  a_miso_quiet: assert property (selectN && $past(selectN) && $past(selectN, 2) |-> !misoOe)
    else $error("miso driven unselected");
  c_irq: cover property (irq);
  c_refused: cover property (rvalid && rresp == 2'h2);
  c_fault: cover property (sckOe && !selectN);
endmodule : spp_assertions

bind spp_top spp_assertions u_chk (.clk, .rst, .awvalid, .awready, .wvalid, .wready, .bresp,
  .bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .sckOe, .mosiOe,
  .selectN, .misoOe, .irq);
`default_nettype wire

// >>> spp_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
// far side serial device: one byte out and one in per frame
module spp_slave_model (
  input wire logic sck,
  input wire logic selN,
  input wire logic mosi,
  input wire logic clock_polarity,
  input wire logic clock_phase,
  input wire logic [7:0] txByte,
  output logic miso,
  output logic [7:0] rxByte
);
  logic [7:0] sh;
  logic bitOut = 1'b0;
  // released line shows the inverse of the last bit
  assign miso = selN ? ~bitOut : bitOut;
  // preload on select; phase 0 puts the first bit out at once
  always @(negedge selN) begin
    sh = txByte;
    if (!clock_phase) begin
      bitOut = sh[7];
      sh = sh << 1;
    end
  end
  // leading edge leaves the idle level; phase picks sample or drive
  always @(sck) begin
    if (!selN) begin
      if ((sck !== clock_polarity) ^ clock_phase) begin
        rxByte = {rxByte[6:0], mosi};
      end else begin
        bitOut = sh[7];
        sh = sh << 1;
      end
    end
  end
endmodule : spp_slave_model
`default_nettype wire

// >>> spp_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "spp_consts.svh"
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module spp_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic sckIn = 0, mosiIn = 1, selectN = 1, modelSel = 1, clock_polarity = 0, clock_phase = 0;
  logic awready, wready, bvalid, arready, rvalid, sckOut, sckOe, mosiOut, mosiOe;
  logic misoOut, misoOe, irq, miso, prevSck, p, q;
  logic [1:0] bresp, rresp, rr;
  logic [7:0] mTx = 8'h0, mRx, b1, b2, sRx;
  int n_errors = 0, n_tests = 0, cyc = 0, nEdge = 0, t0 = 0, t1 = 0;
  wire logic sckLine = sckOe ? sckOut : clock_polarity;
  always #2.5 clk = ~clk;
  spp_top u_spp_top (.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .sckIn, .sckOut, .sckOe, .mosiIn, .mosiOut, .mosiOe, .misoIn(miso), .misoOut,
    .misoOe, .selectN, .irq);
  spp_slave_model u_spp_slave_model (.sck(sckLine), .selN(modelSel), .mosi(mosiOut),
    .clock_polarity, .clock_phase, .txByte(mTx), .miso, .rxByte(mRx));
  task automatic wrap_up;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // serial clock edge times and the run limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prevSck <= sckOut;
    if (sckOe && sckOut !== prevSck) begin
      if (nEdge == 0) t0 <= cyc;
      t1 <= cyc;
      nEdge <= nEdge + 1;
    end
    if (cyc == 60000) begin
      n_errors++;
      wrap_up();
    end
  end
  function automatic int half(input int k);
    return (k == 0) ? 1 : (k == 1) ? 2 : (k == 2) ? 8 : 16;
  endfunction : half
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rr = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [5:0] i);
    araddr <= {i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rv = rdata;
    rr = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic go(input logic [7:0] d, input logic [7:0] m);
    mTx <= m;
    modelSel <= 1'b0;
    @(posedge clk);
    nEdge = 0;
    wr(`SPP_IDX_DATA, d);
  endtask : go
  task automatic fin;
    while (nEdge < 16) begin
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
    modelSel <= 1'b1;
    @(posedge clk);
  endtask : fin
  initial begin
    void'($urandom(29428));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`SPP_IDX_CONTROL);
    `CHK("control", 32'h0, rv)
    rd(`SPP_IDX_STATUS);
    `CHK("status", 32'h0, rv)
    rd(6'h01);
    `CHK("unmapped", `SPP_RESP_SLVERR, rr)
    wr(6'h01, 8'h00);
    `CHK("unmapped wr", `SPP_RESP_SLVERR, rr)
    // master transfers at every rate, polarity and phase taken from the rate code
    for (int k = 0; k < 4; k++) begin
      {p, q} = 2'(k);
      b1 = 8'($urandom);
      b2 = 8'($urandom);
      clock_polarity <= p;
      clock_phase <= q;
      wr(`SPP_IDX_CONTROL, {4'hd, p, q, 2'(k)});
      go(b1, b2);
      fin();
      `CHK("half period", 15 * half(k), t1 - t0)
      `CHK("sent", b1, mRx)
      `CHK("idle", p, sckOut)
      `CHK("irq", 1'b1, irq)
      rd(`SPP_IDX_STATUS);
      `CHK("done", 32'h80, rv)
      rd(`SPP_IDX_DATA);
      `CHK("rx", {24'h0, b2}, rv)
      rd(`SPP_IDX_STATUS);
      `CHK("cleared", 32'h0, rv)
      `CHK("irq off", 1'b0, irq)
    end
    // second data write while shifting
    go(b1, b2);
    wr(`SPP_IDX_DATA, ~b1);
    fin();
    `CHK("kept", b1, mRx)
    rd(`SPP_IDX_STATUS);
    `CHK("collision", 32'hc0, rv)
    rd(`SPP_IDX_DATA);
    rd(`SPP_IDX_STATUS);
    `CHK("col clear", 32'h0, rv)
    // overrun keeps the first byte, then event interrupt paths
    wr(`SPP_IDX_EVT_CLEAR, 8'hf);
    go(b1, b2);
    fin();
    go(b1, ~b2);
    fin();
    rd(`SPP_IDX_STATUS);
    rd(`SPP_IDX_DATA);
    `CHK("overrun", {24'h0, b2}, rv)
    rd(`SPP_IDX_EVT_STATUS);
    `CHK("events", 32'h9, rv)
    wr(`SPP_IDX_EVT_CLEAR, 8'h1);
    wr(`SPP_IDX_EVT_ENABLE, 8'h0);
    `CHK("masked", 1'b0, irq)
    wr(`SPP_IDX_EVT_ENABLE, 8'h8);
    rd(`SPP_IDX_EVT_ENABLE);
    `CHK("enable", 32'h8, rv)
    `CHK("raised", 1'b1, irq)
    wr(`SPP_IDX_EVT_CLEAR, 8'h8);
    `CHK("ev clear", 1'b0, irq)
    // foreign select while master
    selectN <= 1'b0;
    repeat (4) @(posedge clk);
    selectN <= 1'b1;
    rd(`SPP_IDX_STATUS);
    `CHK("fault", 32'h10, rv)
    rd(`SPP_IDX_CONTROL);
    `CHK("master off", 1'b0, rv[4])
    wr(`SPP_IDX_CONTROL, 8'h43);
    rd(`SPP_IDX_STATUS);
    `CHK("fault clear", 32'h0, rv)
    // system off, then open drain clock pin in master mode
    wr(`SPP_IDX_CONTROL, 8'h13);
    wr(`SPP_IDX_DATA, 8'h5a);
    repeat (8) @(posedge clk);
    `CHK("off", 1'b0, sckOe)
    wr(`SPP_IDX_CONTROL, 8'h73);
    `CHK("od low", 1'b1, sckOe)
    wr(`SPP_IDX_CONTROL, 8'h7b);
    `CHK("od high", 1'b0, sckOe)
    wr(`SPP_IDX_CONTROL, 8'h43);
    // slave byte clocked by the bench
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    clock_polarity <= 1'b0;
    clock_phase <= 1'b0;
    wr(`SPP_IDX_DATA, b1);
    repeat (20) @(posedge clk);
    `CHK("no clock", 1'b0, sckOe)
    selectN <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosiIn <= b2[i];
      repeat (4) @(posedge clk);
      sRx[i] = misoOut;
      sckIn <= 1'b1;
      repeat (4) @(posedge clk);
      sckIn <= 1'b0;
    end
    repeat (4) @(posedge clk);
    selectN <= 1'b1;
    mosiIn <= ~mosiIn;
    `CHK("slave sent", b1, sRx)
    rd(`SPP_IDX_STATUS);
    `CHK("slave done", 32'h80, rv)
    rd(`SPP_IDX_DATA);
    `CHK("slave rx", {24'h0, b2}, rv)
    wrap_up();
  end
endmodule : spp_top_tb
`default_nettype wire
